// File: rtl/bcce_pkg.sv
// Shared constants and types for the branch, clear and compare execution slice
package bcce_pkg;
    localparam int BCCE_WORD_W = 32;
    localparam int BCCE_BRANCH_OFF_W = 10;
    localparam int BCCE_CALL_OFF_W = 21;
    localparam int BCCE_OFF_SHIFT = 2;
    localparam int BCCE_FIELD_POS_W = 5;
    localparam int BCCE_HIGH_POS_LSB = 0;
    localparam int BCCE_LOW_POS_LSB = 5;
    localparam int BCCE_HALF_W = 16;
    localparam int BCCE_CONST5_W = 5;
    localparam logic [2:0] BCCE_DELAY_SLOTS = 3'h5;
    localparam logic [2:0] BCCE_SLOT_RESET = 3'h0;
    localparam logic [4:0] BCCE_SIDE_A_LINK = 5'h03;
    localparam logic [4:0] BCCE_SIDE_B_LINK = 5'h03;

    typedef enum logic [2:0]
    {
        BCCE_OP_NONE = 3'h0,
        BCCE_OP_BRANCH_NONNEG = 3'h1,
        BCCE_OP_CALL = 3'h2,
        BCCE_OP_CLEAR = 3'h3,
        BCCE_OP_CMP_WORD = 3'h4,
        BCCE_OP_CMP_HALVES = 3'h5
    } bcce_op_t;

    typedef enum logic [1:0]
    {
        BCCE_ST_IDLE = 2'b00,
        BCCE_ST_SLOTS = 2'b01,
        BCCE_ST_STALL = 2'b11
    } bcce_state_t;
endpackage

// File: rtl/bcce_if.sv
// Issue and result interface between pipeline and execution slice
`timescale 1ns/1ps
interface bcce_if;
    import bcce_pkg::*;
    logic issue_valid;
    bcce_op_t op;
    logic pred_true;
    logic unit_b;
    logic use_const;
    logic [31:0] src1;
    logic [31:0] src2;
    logic [4:0] const5;
    logic [4:0] field_low_const;
    logic [4:0] field_high_const;
    logic [9:0] branch_offset;
    logic [20:0] call_offset;
    logic [4:0] dst_index;
    logic [31:0] execute_stage_packet_address;
    logic [31:0] next_packet_address;
    logic target_split;
    logic second_fetch_ready;
    logic stall;
    logic int_block;
    logic pfc_load;
    logic [31:0] program_fetch_counter;
    logic wr_en;
    logic wr_side_b;
    logic [4:0] wr_index;
    logic [31:0] wr_data;
    logic nop_slot;

    modport exec
    (
        input issue_valid, op, pred_true, unit_b, use_const, src1, src2, const5,
        input field_low_const, field_high_const, branch_offset, call_offset, dst_index,
        input execute_stage_packet_address, next_packet_address, target_split,
        input second_fetch_ready,
        output stall, int_block, pfc_load, program_fetch_counter, wr_en, wr_side_b,
        output wr_index, wr_data, nop_slot
    );
    modport pipe
    (
        output issue_valid, op, pred_true, unit_b, use_const, src1, src2, const5,
        output field_low_const, field_high_const, branch_offset, call_offset, dst_index,
        output execute_stage_packet_address, next_packet_address, target_split,
        output second_fetch_ready,
        input stall, int_block, pfc_load, program_fetch_counter, wr_en, wr_side_b,
        input wr_index, wr_data, nop_slot
    );
endinterface

// File: rtl/bcce_exec.sv
// Execution slice for nonnegative branch, call, bit-field clear and equality compares
// Summary of operation
// - At most one nonnegative branch per packet.
// - Branch needs predicate and nonnegative test.
// - Interrupts blocked during branch delay slots.
// - Stall until split target fetch arrives.
// - No add-constant-to-pc beside these branches.
// - Call target is offset times four plus packet.
// - Call writes return address to link register.
// - Call inserts five implied no-op cycles.
// - Call never paired with other branches.
// - Clear field bits low to high inclusive.
// - Register form positions from source bits 9..0.
// - Upper 22 position bits kept zero.
// - High below low copies source unchanged.
// - Word compare writes one or zero.
// - Each 16-bit half compared independently.
// - Half results in bits 0,1, rest zero.
// - Branch target is offset times four plus packet.
// - Branch only when tested register nonnegative.
`timescale 1ns/1ps
module bcce_exec
    import bcce_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    bcce_if.exec bus
);
    function automatic logic [31:0] bcce_clear(input logic [31:0] word,
        input logic [4:0] low, input logic [4:0] high);
        logic [31:0] mask;
        mask = '0;
        for (int i = 0; i < BCCE_WORD_W; i++)
        begin
            mask[i] = (i >= int'(low)) && (i <= int'(high));
        end
        return word & ~mask;
    endfunction

    bcce_state_t state_reg, state_next;
    logic [2:0] slot_reg, slot_next;
    logic [31:0] pfc_reg;
    logic pfc_load_reg;
    logic wr_en_reg;
    logic wr_side_b_reg;
    logic [4:0] wr_index_reg;
    logic [31:0] wr_data_reg;

    wire accept = bus.issue_valid && !bus.stall;
    wire is_branch = bus.op == BCCE_OP_BRANCH_NONNEG;
    wire is_call = bus.op == BCCE_OP_CALL;
    wire nonneg = !bus.src2[BCCE_WORD_W-1];
    wire branch_taken = accept && is_branch && bus.pred_true && nonneg;
    wire call_go = accept && is_call;
    wire [31:0] branch_target = bus.execute_stage_packet_address
        + 32'({{(32-BCCE_BRANCH_OFF_W){bus.branch_offset[BCCE_BRANCH_OFF_W-1]}},
        bus.branch_offset} << BCCE_OFF_SHIFT);
    wire [31:0] call_target = bus.execute_stage_packet_address
        + 32'({{(32-BCCE_CALL_OFF_W){bus.call_offset[BCCE_CALL_OFF_W-1]}},
        bus.call_offset} << BCCE_OFF_SHIFT);
    wire [4:0] reg_high = bus.src1[BCCE_HIGH_POS_LSB +: BCCE_FIELD_POS_W];
    wire [4:0] reg_low = bus.src1[BCCE_LOW_POS_LSB +: BCCE_FIELD_POS_W];
    wire [4:0] fld_high = bus.use_const ? bus.field_high_const : reg_high;
    wire [4:0] fld_low = bus.use_const ? bus.field_low_const : reg_low;
    wire [31:0] clear_result = (fld_high >= fld_low)
        ? bcce_clear(bus.src2, fld_low, fld_high) : bus.src2;
    wire [31:0] cmp_a = bus.use_const
        ? {{(32-BCCE_CONST5_W){bus.const5[BCCE_CONST5_W-1]}}, bus.const5} : bus.src1;
    wire [31:0] cmp_word_result = {31'h0000_0000, cmp_a == bus.src2};
    // packed into bits 0 and 1
    wire [31:0] cmp_half_result = {30'h0000_0000,
        bus.src1[BCCE_HALF_W +: BCCE_HALF_W] == bus.src2[BCCE_HALF_W +: BCCE_HALF_W],
        bus.src1[0 +: BCCE_HALF_W] == bus.src2[0 +: BCCE_HALF_W]};
    wire alu_op = bus.op == BCCE_OP_CLEAR || bus.op == BCCE_OP_CMP_WORD
        || bus.op == BCCE_OP_CMP_HALVES;
    wire alu_write = accept && alu_op && bus.pred_true;
    logic [31:0] alu_result;
    always_comb
    begin
        unique case (bus.op)
            BCCE_OP_CLEAR: alu_result = clear_result;
            BCCE_OP_CMP_WORD: alu_result = cmp_word_result;
            BCCE_OP_CMP_HALVES: alu_result = cmp_half_result;
            default: alu_result = 32'h0000_0000;
        endcase
    end

    wire any_branch = accept && (is_branch || is_call);
    wire slots_done = slot_reg == BCCE_DELAY_SLOTS;
    always_comb
    begin
        state_next = state_reg;
        slot_next = slot_reg;
        unique case (state_reg)
            BCCE_ST_IDLE:
            begin
                if (any_branch)
                begin
                    state_next = BCCE_ST_SLOTS;
                    slot_next = 3'h1;
                end
            end
            BCCE_ST_SLOTS:
            begin
                slot_next = 3'(slot_reg + 3'h1);
                if (slots_done)
                begin
                    state_next = bus.target_split ? BCCE_ST_STALL : BCCE_ST_IDLE;
                    slot_next = BCCE_SLOT_RESET;
                end
            end
            BCCE_ST_STALL:
            begin
                if (bus.second_fetch_ready)
                begin
                    state_next = BCCE_ST_IDLE;
                end
            end
            default:
            begin
                state_next = BCCE_ST_IDLE;
                slot_next = BCCE_SLOT_RESET;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= BCCE_ST_IDLE;
            slot_reg <= BCCE_SLOT_RESET;
        end
        else if (clk_en)
        begin
            state_reg <= state_next;
            slot_reg <= slot_next;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pfc_load_reg <= 1'b0;
            pfc_reg <= 32'h0000_0000;
        end
        else if (clk_en)
        begin
            pfc_load_reg <= branch_taken || call_go;
            if (call_go)
            begin
                pfc_reg <= call_target;
            end
            else if (branch_taken)
            begin
                pfc_reg <= branch_target;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_en_reg <= 1'b0;
            wr_side_b_reg <= 1'b0;
            wr_index_reg <= 5'h00;
            wr_data_reg <= 32'h0000_0000;
        end
        else if (clk_en)
        begin
            wr_en_reg <= alu_write || call_go;
            wr_side_b_reg <= bus.unit_b;
            if (call_go)
            begin
                wr_index_reg <= bus.unit_b ? BCCE_SIDE_B_LINK : BCCE_SIDE_A_LINK;
                wr_data_reg <= bus.next_packet_address;
            end
            else if (alu_write)
            begin
                wr_index_reg <= bus.dst_index;
                wr_data_reg <= alu_result;
            end
        end
    end

    assign bus.int_block = state_reg != BCCE_ST_IDLE;
    assign bus.stall = state_reg == BCCE_ST_STALL;
    assign bus.nop_slot = state_reg == BCCE_ST_SLOTS;
    assign bus.pfc_load = pfc_load_reg;
    assign bus.program_fetch_counter = pfc_reg;
    assign bus.wr_en = wr_en_reg;
    assign bus.wr_side_b = wr_side_b_reg;
    assign bus.wr_index = wr_index_reg;
    assign bus.wr_data = wr_data_reg;
endmodule // bcce_exec

// File: rtl/bcce_pipe.sv
// Pipeline-side issue end, one packet per request
`timescale 1ns/1ps
module bcce_pipe
    import bcce_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic req_valid,
    input wire logic [2:0] req_op,
    input wire logic req_pred_true,
    input wire logic req_unit_b,
    input wire logic req_use_const,
    input wire logic [31:0] req_src1,
    input wire logic [31:0] req_src2,
    input wire logic [4:0] req_const5,
    input wire logic [4:0] req_field_low,
    input wire logic [4:0] req_field_high,
    input wire logic [9:0] req_branch_offset,
    input wire logic [20:0] req_call_offset,
    input wire logic [4:0] req_dst_index,
    input wire logic [31:0] req_packet_address,
    input wire logic [31:0] req_next_packet_address,
    input wire logic req_target_split,
    input wire logic req_second_fetch_ready,
    output logic req_ready,
    output logic req_dropped,
    output logic int_block,
    output logic pfc_load,
    output logic [31:0] pfc_value,
    output logic rf_wr_en,
    output logic rf_wr_side_b,
    output logic [4:0] rf_wr_index,
    output logic [31:0] rf_wr_data,
    bcce_if.pipe bus
);
    wire req_is_branch = req_op == 3'(BCCE_OP_BRANCH_NONNEG) || req_op == 3'(BCCE_OP_CALL);
    wire branch_blocked = req_is_branch && bus.int_block;
    logic dropped_reg;
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dropped_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            dropped_reg <= req_valid && branch_blocked && !bus.stall;
        end
    end
    assign bus.issue_valid = req_valid && !branch_blocked;
    assign bus.op = bcce_op_t'(req_op);
    assign bus.pred_true = req_pred_true;
    assign bus.unit_b = req_unit_b;
    assign bus.use_const = req_use_const;
    assign bus.src1 = (req_op == 3'(BCCE_OP_CLEAR) && !req_use_const)
        ? {22'h00_0000, req_src1[9:0]} : req_src1;
    assign bus.src2 = req_src2;
    assign bus.const5 = req_const5;
    assign bus.field_low_const = req_field_low;
    assign bus.field_high_const = req_field_high;
    assign bus.branch_offset = req_branch_offset;
    assign bus.call_offset = req_call_offset;
    assign bus.dst_index = req_dst_index;
    assign bus.execute_stage_packet_address = req_packet_address;
    assign bus.next_packet_address = req_next_packet_address;
    assign bus.target_split = req_target_split;
    assign bus.second_fetch_ready = req_second_fetch_ready;
    assign req_ready = !bus.stall;
    assign req_dropped = dropped_reg;
    assign int_block = bus.int_block;
    assign pfc_load = bus.pfc_load;
    assign pfc_value = bus.program_fetch_counter;
    assign rf_wr_en = bus.wr_en;
    assign rf_wr_side_b = bus.wr_side_b;
    assign rf_wr_index = bus.wr_index;
    assign rf_wr_data = bus.wr_data;
endmodule // bcce_pipe

// File: verification/bcce_exec_chk.sv
// Concurrent checks on the pipeline to execution slice interface
`timescale 1ns/1ps
module bcce_exec_chk
    import bcce_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic issue_valid,
    input wire bcce_op_t op,
    input wire logic pred_true,
    input wire logic unit_b,
    input wire logic use_const,
    input wire logic [31:0] src1,
    input wire logic [31:0] src2,
    input wire logic [4:0] const5,
    input wire logic [4:0] field_low_const,
    input wire logic [4:0] field_high_const,
    input wire logic [9:0] branch_offset,
    input wire logic [20:0] call_offset,
    input wire logic [4:0] dst_index,
    input wire logic [31:0] execute_stage_packet_address,
    input wire logic [31:0] next_packet_address,
    input wire logic second_fetch_ready,
    input wire logic stall,
    input wire logic int_block,
    input wire logic pfc_load,
    input wire logic [31:0] program_fetch_counter,
    input wire logic wr_en,
    input wire logic wr_side_b,
    input wire logic [4:0] wr_index,
    input wire logic [31:0] wr_data,
    input wire logic nop_slot
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic [4:0] lo, hi;
    logic [31:0] clr_exp, br_tgt, call_tgt, cmp_a, pkt;
    logic brq, callq, aluq;
    assign pkt = execute_stage_packet_address;
    assign lo = use_const ? field_low_const : src1[9:5];
    assign hi = use_const ? field_high_const : src1[4:0];
    assign cmp_a = use_const ? {{27{const5[4]}}, const5} : src1;
    assign br_tgt = pkt + {{20{branch_offset[9]}}, branch_offset, 2'b00};
    assign call_tgt = pkt + {{9{call_offset[20]}}, call_offset, 2'b00};
    assign brq = issue_valid && op == BCCE_OP_BRANCH_NONNEG && !int_block;
    assign callq = issue_valid && op == BCCE_OP_CALL && !int_block;
    assign aluq = issue_valid && !stall
        && op inside {BCCE_OP_CLEAR, BCCE_OP_CMP_WORD, BCCE_OP_CMP_HALVES};
    always_comb
    begin
        clr_exp = src2;
        for (int i = 0; i < 32; i++)
            if (hi >= lo && i >= lo && i <= hi) clr_exp[i] = 1'b0;
    end
    chk_branch_target: assert property (
        brq && pred_true && !src2[31] |=> pfc_load && program_fetch_counter == $past(br_tgt))
        else $error("branch target wrong");
    chk_branch_untaken: assert property (
        brq && (!pred_true || src2[31]) |=> !pfc_load) else $error("untaken branch loaded");
    chk_slots_blocked: assert property (
        brq || callq |=> int_block [*5]) else $error("delay slot not blocked");
    chk_call_target: assert property (
        callq |=> pfc_load && program_fetch_counter == $past(call_tgt))
        else $error("call target wrong");
    chk_call_link: assert property (
        callq |=> wr_en && wr_index == 5'h03 && wr_side_b == $past(unit_b)
        && wr_data == $past(next_packet_address)) else $error("call link write wrong");
    chk_call_nops: assert property (
        callq |=> nop_slot [*5] ##1 !nop_slot) else $error("call nop slots wrong");
    chk_stall_hold: assert property (
        stall && !second_fetch_ready |=> stall && int_block) else $error("stall released early");
    chk_clear_value: assert property (
        aluq && op == BCCE_OP_CLEAR && pred_true |=> wr_en && wr_data == $past(clr_exp)
        && wr_index == $past(dst_index)) else $error("clear result wrong");
    chk_word_cmp: assert property (
        aluq && op == BCCE_OP_CMP_WORD && pred_true |=> wr_en
        && wr_data == {31'h0, $past(cmp_a == src2)}) else $error("word compare wrong");
    chk_halves_cmp: assert property (
        aluq && op == BCCE_OP_CMP_HALVES && pred_true |=> wr_en && wr_data == {30'h0,
        $past(src1[31:16] == src2[31:16]), $past(src1[15:0] == src2[15:0])})
        else $error("halves compare wrong");
    chk_pred_false: assert property (
        aluq && !pred_true |=> !wr_en) else $error("false predicate wrote");
    cover property (callq);
    cover property (stall);
    cover property (brq && pred_true && !src2[31]);
endmodule // bcce_exec_chk

// File: verification/testbench.sv
// Self-checking bench joining pipeline end and execution end
`timescale 1ns/1ps
module testbench;
    import bcce_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic req_valid, req_pred_true, req_unit_b, req_use_const, req_target_split;
    logic req_second_fetch_ready, req_ready, req_dropped, int_block, pfc_load;
    logic rf_wr_en, rf_wr_side_b;
    logic [2:0] req_op;
    logic [4:0] req_const5, req_field_low, req_field_high, req_dst_index, rf_wr_index, lo, hi;
    logic [9:0] req_branch_offset;
    logic [20:0] req_call_offset;
    logic [31:0] req_src1, req_src2, req_packet_address, req_next_packet_address;
    logic [31:0] pfc_value, rf_wr_data, ex;
    logic [31:0] seed = 32'h0000_a16d;
    logic [37:0] wq[$];
    logic [31:0] pq[$];
    int fail_count = 0;
    int check_count = 0;
    int cyc = 0;
    int n;
    bcce_if link();
    bcce_exec u_bcce_exec (.ref_clk, .rst_n, .clk_en, .bus(link));
    bcce_pipe u_bcce_pipe (.ref_clk, .rst_n, .clk_en, .req_valid, .req_op, .req_pred_true,
        .req_unit_b, .req_use_const, .req_src1, .req_src2, .req_const5, .req_field_low,
        .req_field_high, .req_branch_offset, .req_call_offset, .req_dst_index,
        .req_packet_address, .req_next_packet_address, .req_target_split,
        .req_second_fetch_ready, .req_ready, .req_dropped, .int_block, .pfc_load, .pfc_value,
        .rf_wr_en, .rf_wr_side_b, .rf_wr_index, .rf_wr_data, .bus(link));
    bcce_exec_chk u_bcce_exec_chk (.ref_clk, .rst_n, .issue_valid(link.issue_valid),
        .op(link.op), .pred_true(link.pred_true), .unit_b(link.unit_b),
        .use_const(link.use_const), .src1(link.src1), .src2(link.src2), .const5(link.const5),
        .field_low_const(link.field_low_const), .field_high_const(link.field_high_const),
        .branch_offset(link.branch_offset), .call_offset(link.call_offset),
        .dst_index(link.dst_index),
        .execute_stage_packet_address(link.execute_stage_packet_address),
        .next_packet_address(link.next_packet_address), .stall(link.stall),
        .second_fetch_ready(link.second_fetch_ready), .int_block(link.int_block),
        .pfc_load(link.pfc_load), .program_fetch_counter(link.program_fetch_counter),
        .wr_en(link.wr_en), .wr_side_b(link.wr_side_b), .wr_index(link.wr_index),
        .wr_data(link.wr_data), .nop_slot(link.nop_slot));
    always #20 ref_clk = ~ref_clk;
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic check(input logic [37:0] seen, input logic [37:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic issue(input logic [2:0] op, input logic pred);
        req_op = op;
        req_pred_true = pred;
        req_valid = 1'b1;
        while (req_ready !== 1'b1) @(posedge ref_clk) #1;
        @(posedge ref_clk) #1;
    endtask
    task automatic slots(input int want);
        n = 0;
        req_valid = 1'b0;
        while (int_block === 1'b1 && n < 40)
        begin
            n++;
            @(posedge ref_clk) #1;
        end
        if (want >= 0) check(n, want);
        repeat (2) @(posedge ref_clk) #1;
        check(wq.size() + pq.size(), 0);
    endtask
    always @(negedge ref_clk)
        if (rst_n === 1'b1)
        begin
            if (rf_wr_en === 1'b1)
                check({rf_wr_side_b, rf_wr_index, rf_wr_data},
                    wq.size() ? wq.pop_front() : ~{rf_wr_side_b, rf_wr_index, rf_wr_data});
            if (pfc_load === 1'b1)
                check(pfc_value, pq.size() ? pq.pop_front() : ~pfc_value);
        end
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            fail_count++;
            end_of_test();
        end
    end
    initial
    begin
        {req_valid, req_pred_true, req_unit_b, req_use_const, req_target_split} = 5'h00;
        {req_op, req_src1, req_src2, req_const5, req_field_low, req_field_high} = '0;
        {req_branch_offset, req_call_offset, req_dst_index, req_packet_address} = '0;
        req_next_packet_address = 32'h0000_0000;
        req_second_fetch_ready = 1'b1;
        repeat (12) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        @(posedge ref_clk) #1;
        repeat (60)
        begin
            req_src1 = xs();
            req_src2 = xs();
            ex = xs();
            req_use_const = ex[0];
            {req_const5, req_field_low, req_field_high, req_dst_index} = ex[24:5];
            if (ex[26]) req_src2[15:0] = req_src1[15:0];
            if (ex[27]) req_src2[31:16] = req_src1[31:16];
            if (ex[28] && ex[0]) req_src2 = {{27{req_const5[4]}}, req_const5};
            req_op = 3'h3 + 3'(ex[31:29] % 3);
            if (req_op == BCCE_OP_CLEAR && !ex[0]) req_src1[31:10] = 22'h00_0000;
            lo = req_use_const ? req_field_low : req_src1[9:5];
            hi = req_use_const ? req_field_high : req_src1[4:0];
            ex = req_src2;
            for (int i = 0; i < 32; i++)
                if (hi >= lo && i >= lo && i <= hi) ex[i] = 1'b0;
            if (req_op == BCCE_OP_CMP_WORD)
                ex = {31'h0, (req_use_const ? {{27{req_const5[4]}}, req_const5}
                    : req_src1) == req_src2};
            if (req_op == BCCE_OP_CMP_HALVES)
                ex = {30'h0, req_src1[31:16] == req_src2[31:16], req_src1[15:0] == req_src2[15:0]};
            req_pred_true = |seed[2:1];
            if (req_pred_true) wq.push_back({1'b0, req_dst_index, ex});
            issue(req_op, req_pred_true);
        end
        slots(0);
        $display("test alu done");
        for (int c = 0; c < 6; c++)
        begin
            ex = xs();
            req_src2 = xs();
            req_src2[31] = c[0];
            req_branch_offset = ex[9:0];
            req_call_offset = ex[30:10];
            req_unit_b = c[0];
            req_packet_address = xs();
            req_next_packet_address = xs();
            req_target_split = c == 5;
            req_second_fetch_ready = c != 5;
            if (c > 3) wq.push_back({c[0], 5'h03, req_next_packet_address});
            if (c > 3) pq.push_back(req_packet_address + {{9{ex[30]}}, ex[30:10], 2'b00});
            if (c == 0) pq.push_back(req_packet_address + {{20{ex[9]}}, ex[9:0], 2'b00});
            issue(c > 3 ? BCCE_OP_CALL : BCCE_OP_BRANCH_NONNEG, c < 2 || c > 3);
            if (c == 0 || c == 4) issue(c == 4 ? BCCE_OP_CALL : BCCE_OP_BRANCH_NONNEG, 1'b1);
            req_valid = 1'b0;
            if (c == 0) check(req_dropped, 1'b1);
            if (c == 4) check(req_dropped, 1'b1);
            if (c == 3)
            begin
                clk_en = 1'b0;
                repeat (3) @(posedge ref_clk) #1;
                clk_en = 1'b1;
            end
            if (c == 5)
            begin
                repeat (8) @(posedge ref_clk) #1;
                check({req_ready, int_block}, 2'b01);
                req_second_fetch_ready = 1'b1;
            end
            slots(c == 0 || c == 4 ? 4 : (c == 5 ? -1 : 5));
            $display("test branch %0d done", c);
        end
        end_of_test();
    end
endmodule // testbench
